// File: pkg/lvr_defines.svh
// register offsets, field positions, reset values and decode ranges of the vga router
`ifndef LVR_DEFINES_SVH
`define LVR_DEFINES_SVH

`define LVR_OFS_CTRL      8'h00
`define LVR_OFS_STATUS    8'h04
`define LVR_OFS_CNT_GFX   8'h08
`define LVR_OFS_CNT_AGP   8'h0c
`define LVR_OFS_CNT_HUB   8'h10

`define LVR_CTRL_RST      32'h0000_0000
`define LVR_CNT_RST       16'h0000
`define LVR_CTRL_GFX_EN   0
`define LVR_CTRL_VGA_DIS  1
`define LVR_CTRL_GFX_MEM  2
`define LVR_CTRL_GFX_IO   3
`define LVR_CTRL_PWR_LO   4
`define LVR_CTRL_MSR0     6
`define LVR_CTRL_MSR1     7
`define LVR_CTRL_MAP_LO   8
`define LVR_CTRL_BR_MEM   10
`define LVR_CTRL_BR_IO    11
`define LVR_CTRL_VGA_EN   12
`define LVR_CTRL_MONO_ADAPTER_PRESENT     13
`define LVR_CTRL_ISA_EN   14
`define LVR_CTRL_MASK     32'h0000_7fff

`define LVR_STAT_ILLEGAL  8
`define LVR_SUBCODE_VGA   8'h00
`define LVR_SUBCODE_OTHER 8'h80

`define LVR_MEM_VGA_LO    20'ha0000
`define LVR_MEM_A_HI      20'haffff
`define LVR_MEM_MDA_LO    20'hb0000
`define LVR_MEM_MDA_HI    20'hb7fff
`define LVR_MEM_B8_LO     20'hb8000
`define LVR_MEM_VGA_HI    20'hbffff

`define LVR_IO_3B_LO      10'h3b0
`define LVR_IO_3B_HI      10'h3bb
`define LVR_IO_3BC        10'h3bc
`define LVR_IO_3BF        10'h3bf
`define LVR_IO_3C_LO      10'h3c0
`define LVR_IO_3C_HI      10'h3cf
`define LVR_IO_3D_LO      10'h3d0
`define LVR_IO_3D_HI      10'h3df

`endif

// File: pkg/lvr_pkg.sv
// types and shared range helper of the vga router
package lvr_pkg;
   typedef enum logic [1:0]
   {
      LVR_PWR_D0 = 2'b00,
      LVR_PWR_D1 = 2'b01,
      LVR_PWR_D2 = 2'b10,
      LVR_PWR_D3 = 2'b11
   } lvr_pwr_t;

   typedef logic [1:0] lvr_map_t;

   function automatic logic in_range(input logic [19:0] a, input logic [19:0] lo,
                                     input logic [19:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction
endpackage

// File: core/lvr_mem_decode.sv
// legacy vga memory window decode
`timescale 1ns/1ps
`include "lvr_defines.svh"
module lvr_mem_decode
(
   input  wire logic            [19:0] addr,
   input  wire logic                   gfx_qual,
   input  wire lvr_pkg::lvr_map_t      map_sel,
   input  wire logic                   bridge_en,
   input  wire logic                   vga_enable,
   input  wire logic                   mono_adapter_present,
   output logic                        hit,
   output logic                        to_gfx,
   output logic                        to_agp,
   output logic                        to_hub,
   output logic                        illegal
);
   logic in_a;
   logic in_mda;
   logic in_b8;
   logic claim;

   always_comb
   begin
      in_a    = lvr_pkg::in_range(addr, `LVR_MEM_VGA_LO, `LVR_MEM_A_HI);
      in_mda  = lvr_pkg::in_range(addr, `LVR_MEM_MDA_LO, `LVR_MEM_MDA_HI);
      in_b8   = lvr_pkg::in_range(addr, `LVR_MEM_B8_LO, `LVR_MEM_VGA_HI);
      hit     = in_a || in_mda || in_b8;
      claim   = gfx_qual && ((map_sel == 2'h0) || (map_sel == 2'h1 && in_a) ||
                (map_sel == 2'h2 && in_mda) || (map_sel == 2'h3 && in_b8));
      to_gfx  = 1'b0;
      to_agp  = 1'b0;
      to_hub  = 1'b0;
      illegal = 1'b0;
      if (hit && claim)
      begin
         to_gfx = 1'b1;
      end
      else if (hit && bridge_en)
      begin
         to_agp  = vga_enable && !(mono_adapter_present && in_mda);
         to_hub  = !to_agp;
         illegal = !vga_enable && mono_adapter_present;
      end
      else if (hit)
      begin
         to_hub = 1'b1;
      end
   end
endmodule // lvr_mem_decode

// File: core/lvr_io_decode.sv
// legacy vga and mda i/o port decode, ten-bit aliased
`timescale 1ns/1ps
`include "lvr_defines.svh"
module lvr_io_decode
(
   input  wire logic [9:0] port,
   input  wire logic       gfx_qual,
   input  wire logic       misc_output_bit_zero,
   input  wire logic       bridge_en,
   input  wire logic       vga_enable,
   input  wire logic       mono_adapter_present,
   input  wire logic       isa_enable,
   output logic            hit,
   output logic            to_gfx,
   output logic            to_agp,
   output logic            to_hub,
   output logic            illegal
);
   logic [19:0] p;
   logic        r3b;
   logic        r3bc;
   logic        r3c;
   logic        r3d;
   logic        mda;
   logic        vga_port;

   always_comb
   begin
      p        = {10'h000, port};
      r3b      = lvr_pkg::in_range(p, {10'h000, `LVR_IO_3B_LO}, {10'h000, `LVR_IO_3B_HI});
      r3bc     = lvr_pkg::in_range(p, {10'h000, `LVR_IO_3BC}, {10'h000, `LVR_IO_3BF});
      r3c      = lvr_pkg::in_range(p, {10'h000, `LVR_IO_3C_LO}, {10'h000, `LVR_IO_3C_HI});
      r3d      = lvr_pkg::in_range(p, {10'h000, `LVR_IO_3D_LO}, {10'h000, `LVR_IO_3D_HI});
      mda      = (port == 10'h3b4) || (port == 10'h3b5) || (port == 10'h3b8) ||
                 (port == 10'h3b9) || (port == 10'h3ba) || (port == `LVR_IO_3BF);
      vga_port = r3b || r3c || r3d;
      hit      = vga_port || r3bc;
      to_gfx   = 1'b0;
      to_agp   = 1'b0;
      to_hub   = 1'b0;
      illegal  = 1'b0;
      if (hit && gfx_qual && (r3c || (misc_output_bit_zero ? r3d : r3b)))
      begin
         to_gfx = 1'b1;
      end
      else if (hit && bridge_en)
      begin
         illegal = !vga_enable && mono_adapter_present;
         if (!vga_enable)
            to_agp = !mono_adapter_present && r3bc && !isa_enable;
         else
            to_agp = vga_port && !(mono_adapter_present && mda);
         to_hub = !to_agp;
      end
      else if (hit)
      begin
         to_hub = 1'b1;
      end
   end
endmodule // lvr_io_decode

// File: core/lvr_router.sv
// legacy vga/mda cycle router with apb control, status and route counters
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "lvr_defines.svh"
// Notes on behaviour
// - graphics function wins over agp bridge, bridge wins over hub interface.
// - graphics takes memory only if enabled, vga on, memory on, D0, misc bit one.
// - map select 00 claims all windows, 01 a0000, 10 b0000, 11 b8000.
// - without graphics, legacy memory decode needs bridge memory enable; vga and mda windows.
// - memory: 00 hub, 10 agp, 11 mda hub rest agp, 01 illegal.
// - bridge access enable clear sends the vga cycle to the hub interface.
// - graphics takes i/o only if enabled, vga on, i/o on, and D0.
// - graphics claims 3cx; misc bit zero low adds 3b0-3bb, high adds 3dx.
// - legacy i/o: 3b0-3bb and 3c0-3df vga, six listed mda ports.
// - i/o 00 goes to hub, 3bc-3bf to agp when isa enable clear.
// - i/o 10 sends vga ports to agp, others to hub; 01 illegal.
// - i/o 11 sends vga to agp, mda and 3bc-3be to hub.
// - vga disable stops all graphics claims; subclass reads 80h instead of 00h.
module lvr_router
#(
   parameter int ADDR_W  = 32,
   parameter int PADDR_W = 12
)
(
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [PADDR_W-1:0] paddr,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   input  wire logic               cyc_valid,
   input  wire logic               cyc_io,
   input  wire logic [ADDR_W-1:0]  cyc_addr,
   output logic                    route_valid,
   output logic                    route_gfx,
   output logic                    route_agp,
   output logic                    route_hub
);
   initial
   begin
      if (ADDR_W < 20 || ADDR_W > 64)
         $error("lvr_router: ADDR_W must lie in 20..64");
      if (PADDR_W < 8 || PADDR_W > 32)
         $error("lvr_router: PADDR_W must lie in 8..32");
   end

   function automatic logic reg_hit(input logic [PADDR_W-1:0] a, input logic [7:0] ofs);
      reg_hit = (a[7:0] == ofs) && ((a >> 8) == '0);
   endfunction

   logic [31:0] ctrl;
   logic        illegal_seen;
   logic [15:0] cnt_gfx;
   logic [15:0] cnt_agp;
   logic [15:0] cnt_hub;

   logic        graphics_enable_bit;
   logic        graphics_vga_disable;
   logic        gfx_mem_en;
   logic        gfx_io_en;
   logic        gfx_in_d0;
   logic        misc_output_bit_zero;
   logic        misc_output_bit_one;
   logic        bridge_mem_en;
   logic        bridge_io_en;
   logic        vga_enable;
   logic        mono_adapter_present;
   logic        isa_enable;
   lvr_pkg::lvr_map_t graphics_memory_map_select;
   logic [7:0]  class_subcode;

   logic        gfx_mem_qual;
   logic        gfx_io_qual;
   logic        below_1m;
   logic        mem_hit;
   logic        mem_gfx;
   logic        mem_agp;
   logic        mem_hub;
   logic        mem_bad;
   logic        io_hit;
   logic        io_gfx;
   logic        io_agp;
   logic        io_hub;
   logic        io_bad;
   logic        next_gfx;
   logic        next_agp;
   logic        next_hub;
   logic        next_bad;

   logic        acc_wr;
   logic        acc_rd_setup;
   logic        sel_ctrl;
   logic        sel_stat;
   logic        sel_cg;
   logic        sel_ca;
   logic        sel_ch;
   logic        mapped;

   always_comb
   begin
      graphics_enable_bit        = ctrl[`LVR_CTRL_GFX_EN];
      graphics_vga_disable       = ctrl[`LVR_CTRL_VGA_DIS];
      gfx_mem_en                 = ctrl[`LVR_CTRL_GFX_MEM];
      gfx_io_en                  = ctrl[`LVR_CTRL_GFX_IO];
      gfx_in_d0                  = ctrl[`LVR_CTRL_PWR_LO +: 2] == lvr_pkg::LVR_PWR_D0;
      misc_output_bit_zero       = ctrl[`LVR_CTRL_MSR0];
      misc_output_bit_one        = ctrl[`LVR_CTRL_MSR1];
      graphics_memory_map_select = ctrl[`LVR_CTRL_MAP_LO +: 2];
      bridge_mem_en              = ctrl[`LVR_CTRL_BR_MEM];
      bridge_io_en               = ctrl[`LVR_CTRL_BR_IO];
      vga_enable                 = ctrl[`LVR_CTRL_VGA_EN];
      mono_adapter_present       = ctrl[`LVR_CTRL_MONO_ADAPTER_PRESENT];
      isa_enable                 = ctrl[`LVR_CTRL_ISA_EN];
   end

   assign gfx_mem_qual = graphics_enable_bit && !graphics_vga_disable && gfx_mem_en &&
                         gfx_in_d0 && misc_output_bit_one;
   assign gfx_io_qual  = graphics_enable_bit && !graphics_vga_disable && gfx_io_en &&
                         gfx_in_d0;
   assign class_subcode = graphics_vga_disable ? `LVR_SUBCODE_OTHER : `LVR_SUBCODE_VGA;
   assign below_1m      = (cyc_addr >> 20) == '0;

   lvr_mem_decode u_mem
   (
      .addr                 (cyc_addr[19:0]),
      .gfx_qual             (gfx_mem_qual),
      .map_sel              (graphics_memory_map_select),
      .bridge_en            (bridge_mem_en),
      .vga_enable           (vga_enable),
      .mono_adapter_present (mono_adapter_present),
      .hit                  (mem_hit),
      .to_gfx               (mem_gfx),
      .to_agp               (mem_agp),
      .to_hub               (mem_hub),
      .illegal              (mem_bad)
   );

   lvr_io_decode u_io
   (
      .port                 (cyc_addr[9:0]),
      .gfx_qual             (gfx_io_qual),
      .misc_output_bit_zero (misc_output_bit_zero),
      .bridge_en            (bridge_io_en),
      .vga_enable           (vga_enable),
      .mono_adapter_present (mono_adapter_present),
      .isa_enable           (isa_enable),
      .hit                  (io_hit),
      .to_gfx               (io_gfx),
      .to_agp               (io_agp),
      .to_hub               (io_hub),
      .illegal              (io_bad)
   );

   // one destination per cycle, priority order
   always_comb
   begin
      next_gfx = 1'b0;
      next_agp = 1'b0;
      next_hub = 1'b0;
      next_bad = 1'b0;
      if (cyc_valid && cyc_io && io_hit)
      begin
         next_gfx = io_gfx;
         next_agp = io_agp && !io_gfx;
         next_hub = io_hub && !io_gfx && !io_agp;
         next_bad = io_bad;
      end
      else if (cyc_valid && !cyc_io && below_1m && mem_hit)
      begin
         next_gfx = mem_gfx;
         next_agp = mem_agp && !mem_gfx;
         next_hub = mem_hub && !mem_gfx && !mem_agp;
         next_bad = mem_bad;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         route_valid <= 1'b0;
         route_gfx   <= 1'b0;
         route_agp   <= 1'b0;
         route_hub   <= 1'b0;
      end
      else
      begin
         route_valid <= cyc_valid;
         route_gfx   <= next_gfx;
         route_agp   <= next_agp;
         route_hub   <= next_hub;
      end
   end

   // apb slave, zero wait states
   assign acc_wr       = psel && penable && pwrite;
   assign acc_rd_setup = psel && !penable && !pwrite;
   assign sel_ctrl     = reg_hit(paddr, `LVR_OFS_CTRL);
   assign sel_stat     = reg_hit(paddr, `LVR_OFS_STATUS);
   assign sel_cg       = reg_hit(paddr, `LVR_OFS_CNT_GFX);
   assign sel_ca       = reg_hit(paddr, `LVR_OFS_CNT_AGP);
   assign sel_ch       = reg_hit(paddr, `LVR_OFS_CNT_HUB);
   assign mapped       = sel_ctrl || sel_stat || sel_cg || sel_ca || sel_ch;
   assign pready       = 1'b1;
   assign pslverr      = psel && penable && !mapped;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl <= `LVR_CTRL_RST;
      else if (acc_wr && sel_ctrl)
         ctrl <= pwdata & `LVR_CTRL_MASK;
   end

   // sticky illegal setting seen; a new event wins over the clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         illegal_seen <= 1'b0;
      else if (next_bad)
         illegal_seen <= 1'b1;
      else if (acc_wr && sel_stat && pwdata[`LVR_STAT_ILLEGAL])
         illegal_seen <= 1'b0;
   end

   // route counters; a write to their own offset restarts them, counting a route of that same cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_gfx <= `LVR_CNT_RST;
         cnt_agp <= `LVR_CNT_RST;
         cnt_hub <= `LVR_CNT_RST;
      end
      else
      begin
         if (acc_wr && sel_cg)
            cnt_gfx <= {15'h0000, next_gfx};
         else
            cnt_gfx <= cnt_gfx + {15'h0000, next_gfx};
         if (acc_wr && sel_ca)
            cnt_agp <= {15'h0000, next_agp};
         else
            cnt_agp <= cnt_agp + {15'h0000, next_agp};
         if (acc_wr && sel_ch)
            cnt_hub <= {15'h0000, next_hub};
         else
            cnt_hub <= cnt_hub + {15'h0000, next_hub};
      end
   end

   // read data captured in the setup phase
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (acc_rd_setup)
      begin
         if (sel_ctrl)
            prdata <= ctrl;
         else if (sel_stat)
            prdata <= {23'h000000, illegal_seen, class_subcode};
         else if (sel_cg)
            prdata <= {16'h0000, cnt_gfx};
         else if (sel_ca)
            prdata <= {16'h0000, cnt_agp};
         else if (sel_ch)
            prdata <= {16'h0000, cnt_hub};
         else
            prdata <= 32'h0000_0000;
      end
   end

   a_single_dest: assert property (@(posedge pclk) disable iff (!presetn)
      route_valid |-> !(route_gfx && route_agp) && !(route_gfx && route_hub) &&
                      !(route_agp && route_hub))
      else $error("more than one destination for one cycle");

   a_mem_gfx_qual: assert property (@(posedge pclk) disable iff (!presetn)
      cyc_valid && !cyc_io && !gfx_mem_qual |=> !route_gfx)
      else $error("graphics took memory without qualification");

   a_map_window: assert property (@(posedge pclk) disable iff (!presetn)
      cyc_valid && !cyc_io && below_1m && gfx_mem_qual &&
      graphics_memory_map_select == 2'h1 && cyc_addr[19:16] == 4'hb |=> !route_gfx)
      else $error("map select 01 claimed a b window");

   // vga enable alone sends memory to agp
   a_mem_agp: assert property (@(posedge pclk) disable iff (!presetn)
      cyc_valid && !cyc_io && below_1m && mem_hit && !gfx_mem_qual && bridge_mem_en &&
      vga_enable && !mono_adapter_present |=> route_agp && !route_hub)
      else $error("vga memory not routed to agp");

   // bridge enable clear defaults to hub
   a_default_hub: assert property (@(posedge pclk) disable iff (!presetn)
      cyc_valid && !cyc_io && below_1m && mem_hit && !gfx_mem_qual && !bridge_mem_en
      |=> route_hub && !route_agp)
      else $error("disabled bridge did not default to hub");

   a_io_gfx_qual: assert property (@(posedge pclk) disable iff (!presetn)
      cyc_valid && cyc_io && !gfx_io_qual |=> !route_gfx)
      else $error("graphics took i/o without qualification");

   a_io_3cx: assert property (@(posedge pclk) disable iff (!presetn)
      cyc_valid && cyc_io && gfx_io_qual && cyc_addr[9:4] == 6'h3c |=> route_gfx)
      else $error("3cx not claimed by graphics");

   // isa enable clear sends 3bc-3bf to agp
   a_io_isa_agp: assert property (@(posedge pclk) disable iff (!presetn)
      cyc_valid && cyc_io && !gfx_io_qual && bridge_io_en && !vga_enable &&
      !mono_adapter_present && !isa_enable && cyc_addr[9:2] == 8'hef |=> route_agp)
      else $error("3bc-3bf not sent to agp");

   // mda port to hub with both set
   a_io_mda_hub: assert property (@(posedge pclk) disable iff (!presetn)
      cyc_valid && cyc_io && !gfx_io_qual && bridge_io_en && vga_enable &&
      mono_adapter_present && cyc_addr[9:0] == 10'h3b4 |=> route_hub && !route_agp)
      else $error("mda port not sent to hub");

   a_subcode: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && !pwrite && sel_stat |->
      prdata[7:0] == (graphics_vga_disable ? 8'h80 : 8'h00))
      else $error("class subcode does not follow vga disable");

   a_illegal_hub: assert property (@(posedge pclk) disable iff (!presetn)
      cyc_valid && next_bad |=> !route_agp && route_hub && illegal_seen)
      else $error("illegal setting mishandled");
endmodule // lvr_router

// File: sim/lvr_host_model.sv
// host cycle source standing on the far side of the vga router
`timescale 1ns/1ps
module lvr_host_model
(
   input  wire logic        pclk,
   output logic             cyc_valid,
   output logic             cyc_io,
   output logic      [31:0] cyc_addr
);
   initial
   begin
      cyc_valid = 1'b0;
      cyc_io    = 1'b0;
      cyc_addr  = 32'h0000_0000;
   end

   // one host cycle per clock, driven at the edge
   task automatic issue(input logic io, input logic [31:0] a);
      @(posedge pclk);
      cyc_valid <= 1'b1;
      cyc_io    <= io;
      cyc_addr  <= a;
      #1;
   endtask

   // released bus shows a changing pattern, never the last value
   task automatic idle();
      @(posedge pclk);
      cyc_valid <= 1'b0;
      cyc_io    <= ~cyc_io;
      cyc_addr  <= ~cyc_addr;
      #1;
   endtask
endmodule // lvr_host_model

// File: sim/tb_top.sv
// self-checking bench of the vga router
`timescale 1ns/1ps
module tb_top;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        cyc_valid;
   logic        cyc_io;
   logic [31:0] cyc_addr;
   logic        route_valid;
   logic        route_gfx;
   logic        route_agp;
   logic        route_hub;
   int          mismatches;
   int          n_compared;
   int          cycles = 0;
   logic [31:0] d;
   logic        e;
   logic [3:0]  prev;
   logic        ill_seen;
   logic [15:0] cnt [3];
   logic [32:0] vec [21] = '{33'h0_000a_0000, 33'h0_000a_ffff, 33'h0_000b_0000,
      33'h0_000b_7fff, 33'h0_000b_8000, 33'h0_000b_ffff, 33'h0_0009_ffff, 33'h0_000c_0000,
      33'h0_001a_0000, 33'h1_0000_03b0, 33'h1_0000_03b4, 33'h1_0000_03bb, 33'h1_0000_03bc,
      33'h1_0000_03be, 33'h1_0000_03bf, 33'h1_0000_03c5, 33'h1_0000_03d4, 33'h1_0000_03df,
      33'h1_0000_03af, 33'h1_0000_03e0, 33'h1_0000_07c0};
   logic [14:0] cfg [15] = '{
      15'h0000,
      15'h1c8d,
      15'h1dcd,
      15'h3e8d,
      15'h3f8d,
      15'h1c8f,
      15'h1cbd,
      15'h1c0d,
      15'h1c89,
      15'h1c8c,
      15'h0c00,
      15'h4c00,
      15'h3c00,
      15'h2c00,
      15'h1000};

   lvr_router #(.ADDR_W(32), .PADDR_W(12)) dut
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cyc_valid(cyc_valid), .cyc_io(cyc_io), .cyc_addr(cyc_addr),
      .route_valid(route_valid), .route_gfx(route_gfx), .route_agp(route_agp),
      .route_hub(route_hub)
   );

   lvr_host_model host
   (
      .pclk(pclk), .cyc_valid(cyc_valid), .cyc_io(cyc_io), .cyc_addr(cyc_addr)
   );

   always #4 pclk = ~pclk;

   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         mismatches++;
         close_out();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] w);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= w;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      d = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // expected {illegal, gfx, agp, hub} of one host cycle
   function automatic logic [3:0] ref_route(input logic [14:0] c, input logic [32:0] v);
      logic [31:0] ad;
      logic [9:0]  p;
      logic        a, m, b8, hit, cl, gq, br, ex, sp;
      ad = v[31:0];
      p  = ad[9:0];
      a  = ad >= 32'h000a_0000 && ad <= 32'h000a_ffff;
      m  = ad >= 32'h000b_0000 && ad <= 32'h000b_7fff;
      b8 = ad >= 32'h000b_8000 && ad <= 32'h000b_ffff;
      gq = c[0] && !c[1] && c[5:4] == lvr_pkg::LVR_PWR_D0 && (v[32] ? c[3] : c[2] && c[7]);
      if (v[32])
      begin
         hit = p >= 10'h3b0 && p <= 10'h3df;
         cl  = (p >= 10'h3c0 && p <= 10'h3cf) || (c[6] ? p >= 10'h3d0 : p <= 10'h3bb);
         br  = c[11];
         ex  = p >= 10'h3bc && p <= 10'h3bf;
         sp  = (p inside {10'h3b4, 10'h3b5, 10'h3b8, 10'h3b9, 10'h3ba}) || ex;
      end
      else
      begin
         hit = a || m || b8;
         cl  = c[9:8] == 2'b00 || (c[9:8] == 2'b01 && a) || (c[9:8] == 2'b10 && m)
               || (c[9:8] == 2'b11 && b8);
         br  = c[10];
         ex  = 1'b0;
         sp  = m;
      end
      if (!hit) return 4'b0000;
      if (gq && cl) return 4'b0100;
      if (!br) return 4'b0001;
      case (c[13:12])
         2'b00:   return (ex && !c[14]) ? 4'b0010 : 4'b0001;
         2'b01:   return ex ? 4'b0001 : 4'b0010;
         2'b10:   return 4'b1001;
         default: return sp ? 4'b0001 : 4'b0010;
      endcase
   endfunction

   task automatic step(input logic [32:0] v, input logic [14:0] c, input logic go);
      logic [3:0] r;
      if (go)
         host.issue(v[32], v[31:0]);
      else
         host.idle();
      chk({28'h0, route_valid, route_gfx, route_agp, route_hub}, {28'h0, prev});
      r = go ? ref_route(c, v) : 4'h0;
      ill_seen = ill_seen | r[3];
      cnt[0] = cnt[0] + {15'h0, r[2]};
      cnt[1] = cnt[1] + {15'h0, r[1]};
      cnt[2] = cnt[2] + {15'h0, r[0]};
      prev = {go, r[2:0]};
   endtask

   initial
   begin
      pclk     = 1'b0;
      presetn  = 1'b0;
      psel     = 1'b0;
      penable  = 1'b0;
      pwrite   = 1'b0;
      paddr    = 12'h000;
      pwdata   = 32'h0000_0000;
      prev     = 4'h0;
      ill_seen = 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h000, 32'h0);
      chk(d, 32'h0000_0000);
      apb(1'b0, 12'h004, 32'h0);
      chk(d, 32'h0000_0000);
      apb(1'b1, 12'h000, 32'hffff_ffff);
      apb(1'b0, 12'h000, 32'h0);
      chk({d[30:0], e}, 32'h0000_fffe);
      apb(1'b0, 12'h014, 32'h0);
      chk({d[30:0], e}, 32'h0000_0001);
      for (int k = 0; k < 15; k++)
      begin
         apb(1'b1, 12'h000, {17'h0, cfg[k]});
         for (int i = 0; i < 3; i++)
         begin
            apb(1'b1, 12'h008 + 12'(4 * i), 32'h0);
            cnt[i] = 16'h0000;
         end
         foreach (vec[i]) step(vec[i], cfg[k], 1'b1);
         step(33'h0, cfg[k], 1'b0);
         step(33'h0, cfg[k], 1'b0);
         for (int i = 0; i < 3; i++)
         begin
            apb(1'b0, 12'h008 + 12'(4 * i), 32'h0);
            chk({16'h0, d[15:0]}, {16'h0, cnt[i]});
         end
         apb(1'b0, 12'h004, 32'h0);
         chk({23'h0, d[8:0]}, {23'h0, ill_seen, cfg[k][1], 7'h00});
         if (ill_seen)
         begin
            apb(1'b1, 12'h004, 32'h0000_0100);
            ill_seen = 1'b0;
            apb(1'b0, 12'h004, 32'h0);
            chk({31'h0, d[8]}, 32'h0000_0000);
         end
      end
      close_out();
   end
endmodule // tb_top
